// file: dcp_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module dcp_ctrl #(
  parameter int XSRD = dcp_pkg::XSRD_CLK,
  parameter int PD_MAX = dcp_pkg::PD_MAX_CLK
) (
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_ce,
  dcp_if.ctrl                             bus,
  input  wire logic                       i_req_valid,
  input  wire dcp_pkg::dcp_cmd_type       i_req_cmd,
  input  wire logic [dcp_pkg::BA_W-1:0]   i_req_ba,
  input  wire logic [dcp_pkg::ADDR_W-1:0] i_req_addr,
  input  wire logic [dcp_pkg::DM_W-1:0]   i_req_dm,
  input  wire logic [dcp_pkg::DQ_W-1:0]   i_req_dq,
  input  wire logic                       i_pd_req,
  input  wire logic                       i_sr_req,
  input  wire logic                       i_ocd_cal,
  input  wire logic                       i_odt,
  output logic                            o_req_ready,
  output logic                            o_low_power
);
  import dcp_pkg::*;

  typedef enum logic [1:0] {DCP_ST_RUN, DCP_ST_PD, DCP_ST_SR, DCP_ST_XS} dcp_st_type;
  dcp_st_type          st_q;
  logic [CNT_W-1:0]    cnt_q;
  logic [1:0]          hold_q;
  logic [2:0]          busy_q;
  logic [BANKS-1:0]    open_q;
  logic                go_low;
  logic                can_cmd;

  assign go_low  = st_q == DCP_ST_RUN && hold_q == 2'h0 && busy_q == 3'h0 && !i_ocd_cal &&
                   (i_pd_req || (i_sr_req && open_q == '0)) && !i_req_valid;
  assign can_cmd = st_q == DCP_ST_RUN && bus.cke && hold_q == 2'h0 && !go_low;
  assign o_req_ready = i_req_valid && can_cmd && busy_q == 3'h0 &&
    !(i_req_cmd == DCP_CMD_ACT && open_q[i_req_ba]) &&
    !((i_req_cmd == DCP_CMD_MRS || i_req_cmd == DCP_CMD_REF) && open_q != '0) &&
    (st_q != DCP_ST_XS);
  assign o_low_power = st_q == DCP_ST_PD || st_q == DCP_ST_SR;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q   <= DCP_ST_RUN;
      cnt_q  <= '0;
      hold_q <= 2'h0;
      bus.cke <= 1'b1;
    end else if (i_ce) begin
      if (hold_q != 2'h0) begin
        hold_q <= hold_q - 2'h1;
      end
      unique case (st_q)
        DCP_ST_RUN: if (go_low) begin
          bus.cke <= 1'b0;
          hold_q  <= 2'(CKE_MIN_CLK - 1);
          cnt_q   <= '0;
          st_q    <= i_pd_req ? DCP_ST_PD : DCP_ST_SR;
        end
        DCP_ST_PD: begin
          cnt_q <= cnt_q + 1'b1;
          if (hold_q == 2'h0 && (!i_pd_req || cnt_q >= CNT_W'(PD_MAX - 1))) begin
            bus.cke <= 1'b1;
            hold_q  <= 2'(CKE_MIN_CLK - 1);
            st_q    <= DCP_ST_RUN;
          end
        end
        DCP_ST_SR: if (hold_q == 2'h0 && !i_sr_req) begin
          bus.cke <= 1'b1;
          hold_q  <= 2'(CKE_MIN_CLK - 1);
          cnt_q   <= '0;
          st_q    <= DCP_ST_XS;
        end
        DCP_ST_XS: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q >= CNT_W'(XSRD - 1)) begin
            st_q <= DCP_ST_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_q <= 3'h0;
      open_q <= '0;
    end else if (i_ce) begin
      if (o_req_ready) begin
        busy_q <= (i_req_cmd == DCP_CMD_MRS) ? 3'(MRD_CLK) : 3'(BUSY_CLK);
        if (i_req_cmd == DCP_CMD_ACT) open_q[i_req_ba] <= 1'b1;
        if (i_req_cmd == DCP_CMD_PRE) begin
          if (i_req_addr[10]) open_q <= '0;
          else open_q[i_req_ba] <= 1'b0;
        end
      end else if (busy_q != 3'h0) begin
        busy_q <= busy_q - 3'h1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= 4'hF;
      bus.ba <= '0;
      bus.addr <= '0;
      bus.dm <= '1;
      bus.dq <= '0;
      bus.dq_valid <= 1'b0;
      bus.odt <= 1'b0;
    end else if (i_ce) begin
      bus.odt <= i_odt;
      bus.dq_valid <= o_req_ready && i_req_cmd == DCP_CMD_WR;
      bus.dm <= i_req_dm;
      bus.dq <= i_req_dq;
      bus.ba <= i_req_ba;
      bus.addr <= i_req_addr;
      if (go_low && i_sr_req && !i_pd_req) begin
        {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= 4'h1;
      end else if (o_req_ready) begin
        unique case (i_req_cmd)
          DCP_CMD_MRS: {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= 4'h0;
          DCP_CMD_REF: {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= 4'h1;
          DCP_CMD_PRE: {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= 4'h2;
          DCP_CMD_ACT: {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= 4'h3;
          DCP_CMD_WR:  {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= 4'h4;
          DCP_CMD_RD:  {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= 4'h5;
          default:     {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= 4'h7;
        endcase
      end else begin
        {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= 4'h7;
      end
    end
  end
endmodule : dcp_ctrl
`default_nettype wire

// file: dcp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dcp_if;
  import dcp_pkg::*;
  logic              cke;
  logic              cs_n;
  logic              ras_n;
  logic              cas_n;
  logic              we_n;
  logic [BA_W-1:0]   ba;
  logic [ADDR_W-1:0] addr;
  logic              odt;
  logic [DM_W-1:0]   dm;
  logic [DQ_W-1:0]   dq;
  logic              dq_valid;
  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm, dq, dq_valid);
  modport mem  (input  cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm, dq, dq_valid);
endinterface : dcp_if
`default_nettype wire

// file: dcp_mem.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Controller uses NOP/deselect on CKE edges, REFRESH on self refresh entry
// - CKE fall: open row active, else precharge
// - Self refresh entry by REFRESH, CKE falling
// - CKE low holds self refresh; exit NOP
// - NOP only during tXSNR after exit
// - No READ until 200 clocks after exit
// - No power-down during busy operations
// - CKE holds level three edges minimum
// - Controller bounds power-down for refresh
// - CKE high during driver calibration
// - ODT valid in power-down if enabled
// - No termination in self refresh
// - Controller issues legal combinations only
// - High mask leaves byte unchanged
// - Deselect accepts no new command
// - NOP registers nothing new
// - Mode load only idle, wait tMRD
// - Bank address selects mode register
// - Activate opens row until precharge
// - Precharge before another row
// - Commands sampled on rising edge
// - Self refresh exit asynchronous on CKE
// - DLL off in self refresh
module dcp_mem #(
  parameter int WORDS = 16
) (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_ce,
  dcp_if.mem                               bus,
  input  wire logic [$clog2(WORDS)-1:0]    i_wr_idx,
  output var  dcp_pkg::dcp_pw_type         o_pw_state,
  output var  logic [dcp_pkg::BANKS-1:0]   o_bank_open,
  output var  logic                        o_dll_on,
  output var  logic                        o_odt_active,
  output var  logic                        o_cmd_err,
  output var  logic [dcp_pkg::ADDR_W-1:0]  o_mr_q [4],
  output var  logic [dcp_pkg::DQ_W-1:0]    o_word
);
  import dcp_pkg::*;

  logic                  cke_prev_q;
  dcp_pw_type            pw_q;
  logic [ADDR_W-1:0]     row_q [BANKS];
  logic [DQ_W-1:0]       mem_q [WORDS];
  logic [DQ_W-1:0]       word_d;
  dcp_cmd_type           cmd;
  logic                  idle_n;
  logic                  sr_async;

  logic                  edge_bad;
  logic                  seq_bad;
  logic [1:0]            cke_hold_q;
  logic [1:0]            mrd_q;

  assign cmd    = dcp_decode(bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n);
  assign idle_n = |o_bank_open;
  assign sr_async = (pw_q == DCP_PW_SR) && bus.cke;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cke_prev_q <= 1'b1;
    end else if (i_ce) begin
      cke_prev_q <= bus.cke;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pw_q <= DCP_PW_ON;
    end else if (i_ce) begin
      if (cke_prev_q && !bus.cke) begin
        if (cmd == DCP_CMD_REF && !idle_n) begin
          pw_q <= DCP_PW_SR;
        end else if (idle_n) begin
          pw_q <= DCP_PW_APD;
        end else begin
          pw_q <= DCP_PW_PPD;
        end
      end else if (!cke_prev_q && bus.cke) begin
        pw_q <= DCP_PW_ON;
      end else if (sr_async) begin
        pw_q <= DCP_PW_ON;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cmd_err <= 1'b0;
    end else if (i_ce) begin
      o_cmd_err <= edge_bad || seq_bad;
    end
  end

  // Misuse on a clock-enable edge
  always_comb begin
    edge_bad = 1'b0;
    if (cke_prev_q != bus.cke) begin
      if (bus.cke || pw_q != DCP_PW_ON) begin
        edge_bad = !(cmd == DCP_CMD_NOP || cmd == DCP_CMD_DESEL);
      end else begin
        edge_bad = !(cmd == DCP_CMD_NOP || cmd == DCP_CMD_DESEL || cmd == DCP_CMD_REF);
      end
      if (!bus.cke && cmd == DCP_CMD_REF && idle_n) begin
        edge_bad = 1'b1;
      end
      if (cke_hold_q != 2'h0) begin
        edge_bad = 1'b1;
      end
    end
  end

  // Misuse with the clock enabled
  always_comb begin
    seq_bad = 1'b0;
    if (cke_prev_q && bus.cke) begin
      if (cmd == DCP_CMD_ACT && o_bank_open[bus.ba] && bus.addr != row_q[bus.ba]) begin
        seq_bad = 1'b1;
      end
      if (cmd == DCP_CMD_MRS && idle_n) begin
        seq_bad = 1'b1;
      end
      if (mrd_q != 2'h0 && !(cmd == DCP_CMD_NOP || cmd == DCP_CMD_DESEL)) begin
        seq_bad = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cke_hold_q <= 2'h0;
    end else if (i_ce) begin
      if (cke_prev_q != bus.cke) begin
        cke_hold_q <= 2'(CKE_MIN_CLK - 1);
      end else if (cke_hold_q != 2'h0) begin
        cke_hold_q <= cke_hold_q - 2'h1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mrd_q <= 2'h0;
    end else if (i_ce) begin
      if (cke_prev_q && bus.cke && cmd == DCP_CMD_MRS) begin
        mrd_q <= 2'(MRD_CLK - 1);
      end else if (mrd_q != 2'h0) begin
        mrd_q <= mrd_q - 2'h1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bank_open <= '0;
      for (int i = 0; i < BANKS; i++) begin
        row_q[i] <= '0;
      end
    end else if (i_ce && cke_prev_q && bus.cke) begin
      if (cmd == DCP_CMD_ACT) begin
        o_bank_open[bus.ba] <= 1'b1;
        row_q[bus.ba]       <= bus.addr;
      end else if (cmd == DCP_CMD_PRE) begin
        if (bus.addr[10]) begin
          o_bank_open <= '0;
        end else begin
          o_bank_open[bus.ba] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 4; i++) begin
        o_mr_q[i] <= '0;
      end
    end else if (i_ce && cke_prev_q && bus.cke && cmd == DCP_CMD_MRS) begin
      o_mr_q[bus.ba] <= bus.addr;
    end
  end

  always_comb begin
    word_d = mem_q[i_wr_idx];
    for (int b = 0; b < DM_W; b++) begin
      if (!bus.dm[b]) begin
        word_d[b*8 +: 8] = bus.dq[b*8 +: 8];
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_q[i] <= '0;
      end
      o_word <= '0;
    end else if (i_ce) begin
      if (bus.dq_valid && pw_q == DCP_PW_ON) begin
        mem_q[i_wr_idx] <= word_d;
      end
      o_word <= mem_q[i_wr_idx];
    end
  end

  // Deselect and NOP fall through every branch above untouched
  assign o_pw_state   = pw_q;
  assign o_dll_on     = (pw_q != DCP_PW_SR);
  assign o_odt_active = bus.odt && (pw_q != DCP_PW_SR) &&
                        |(o_mr_q[MR_EMR1] & ODT_EN_MASK);
endmodule : dcp_mem
`default_nettype wire

// file: dcp_pkg.sv
package dcp_pkg;
  localparam int BANKS       = 4;
  localparam int BA_W        = 2;
  localparam int ADDR_W      = 14;
  localparam int DM_W        = 2;
  localparam int DQ_W        = 16;
  localparam int CKE_MIN_CLK = 3;
  localparam int XSRD_CLK    = 200;
  localparam int XSNR_CLK    = 50;
  localparam int MRD_CLK     = 2;
  localparam int BUSY_CLK    = 4;
  localparam int PD_MAX_CLK  = 1000;
  localparam int CNT_W       = 12;
  localparam logic [ADDR_W-1:0] ODT_EN_MASK = 14'h0044;
  localparam logic [BA_W-1:0]   MR_EMR1     = 2'h1;

  typedef enum logic [2:0] {
    DCP_CMD_DESEL, DCP_CMD_NOP, DCP_CMD_MRS, DCP_CMD_REF,
    DCP_CMD_PRE, DCP_CMD_ACT, DCP_CMD_WR, DCP_CMD_RD
  } dcp_cmd_type;

  typedef enum logic [1:0] {
    DCP_PW_ON, DCP_PW_APD, DCP_PW_PPD, DCP_PW_SR
  } dcp_pw_type;

  function automatic dcp_cmd_type dcp_decode(input logic cs_n, input logic ras_n,
                                             input logic cas_n, input logic we_n);
    logic [2:0] c;
    c = {ras_n, cas_n, we_n};
    if (cs_n) return DCP_CMD_DESEL;
    unique case (c)
      3'h7:    return DCP_CMD_NOP;
      3'h0:    return DCP_CMD_MRS;
      3'h1:    return DCP_CMD_REF;
      3'h2:    return DCP_CMD_PRE;
      3'h3:    return DCP_CMD_ACT;
      3'h4:    return DCP_CMD_WR;
      3'h5:    return DCP_CMD_RD;
      default: return DCP_CMD_NOP;
    endcase
  endfunction : dcp_decode
endpackage : dcp_pkg

// file: dcp_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dcp_properties #(
  parameter int XSRD   = 8,
  parameter int PD_MAX = 40
) (
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_rst_n,
  input  wire logic                       cke,
  input  wire logic                       cs_n,
  input  wire logic                       ras_n,
  input  wire logic                       cas_n,
  input  wire logic                       we_n,
  input  wire logic [dcp_pkg::BA_W-1:0]   ba,
  input  wire logic [dcp_pkg::ADDR_W-1:0] addr
);
  import dcp_pkg::*;
  logic [2:0]  c;
  logic        idle;
  logic        cke_q;
  logic        sr_q;
  logic [3:0]  open_q;
  int unsigned xs_q;
  int unsigned pd_q;
  assign c    = {ras_n, cas_n, we_n};
  assign idle = cs_n || c == 3'h7;
  // Open rows seen on the bus
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) open_q <= '0;
    else if (!cs_n && c == 3'h3) open_q[ba] <= 1'b1;
    else if (!cs_n && c == 3'h2) open_q <= addr[10] ? 4'h0 : open_q & ~(4'h1 << ba);
  end
  // Self refresh, exit wait and power-down residency
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cke_q <= 1'b1;
      sr_q  <= 1'b0;
      xs_q  <= 0;
      pd_q  <= 0;
    end else begin
      cke_q <= cke;
      sr_q  <= cke ? 1'b0 : (sr_q || (cke_q && !cs_n && c == 3'h1));
      xs_q  <= (cke && !cke_q && sr_q) ? XSRD - 1 : (xs_q != 0 ? xs_q - 1 : 0);
      pd_q  <= (cke || sr_q) ? 0 : pd_q + 1;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  a_cke_rise_nop: assert property ($rose(cke) |-> idle)
    else $error("command on cke rise");
  a_cke_fall_cmd: assert property ($fell(cke) |-> idle || (!cs_n && c == 3'h1))
    else $error("command on cke fall");
  a_cke_min_hold: assert property ($changed(cke) |=> $stable(cke) [*2])
    else $error("cke pulse too short");
  a_sr_entry_idle: assert property ($fell(cke) && !cs_n && c == 3'h1 |-> open_q == 4'h0)
    else $error("self refresh with open bank");
  a_sr_exit_quiet: assert property (xs_q != 0 |-> idle)
    else $error("command during exit wait");
  a_mrs_all_idle: assert property (!cs_n && cke && c == 3'h0 |-> open_q == 4'h0 ##1 idle)
    else $error("mode load misuse");
  a_act_bank_closed: assert property (!cs_n && cke && c == 3'h3 |-> !open_q[ba])
    else $error("activate on open bank");
  a_busy_no_pd: assert property (cke && !cs_n && c inside {3'h0, 3'h2, 3'h4, 3'h5} |=> cke [*2])
    else $error("power-down during operation");
  a_pd_bounded: assert property (pd_q <= PD_MAX)
    else $error("power-down too long");
endmodule : dcp_properties
`default_nettype wire

// file: tb_ddr2_cke_power_state_commands.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ddr2_cke_power_state_commands;
  import dcp_pkg::*;
  localparam int XS  = 8;
  localparam int PDM = 40;
  logic              clk   = 1'b0;
  logic              rst_n = 1'b0;
  logic              vld   = 1'b0;
  dcp_cmd_type       cmd   = DCP_CMD_NOP;
  logic [1:0]        ba    = 2'h0;
  logic [13:0]       addr  = 14'h0000;
  logic [1:0]        dm    = 2'h0;
  logic [15:0]       dq    = 16'h0000;
  logic              pd    = 1'b0;
  logic              sr    = 1'b0;
  logic              ocd   = 1'b0;
  logic              odt   = 1'b0;
  logic [3:0]        widx  = 4'h3;
  logic              rdy;
  logic              tk;
  dcp_pw_type        pw;
  logic [3:0]        bopen;
  logic              dll;
  logic              odta;
  logic              cerr;
  logic              cerr_seen = 1'b0;
  logic              lp;
  logic [13:0]       mr [4];
  logic [15:0]       word;
  int                err_total = 0;
  int                samples_checked = 0;
  int                cyc = 0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (cerr === 1'b1) cerr_seen = 1'b1;
  end
  dcp_if bus_if ();
  dcp_ctrl #(.XSRD(XS), .PD_MAX(PDM)) dcp_ctrl_inst (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_ce(1'b1), .bus(bus_if), .i_req_valid(vld), .i_req_cmd(cmd), .i_req_ba(ba),
    .i_req_addr(addr), .i_req_dm(dm), .i_req_dq(dq), .i_pd_req(pd), .i_sr_req(sr),
    .i_ocd_cal(ocd), .i_odt(odt), .o_req_ready(rdy), .o_low_power(lp));
  dcp_mem dcp_mem_inst (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(1'b1), .bus(bus_if),
    .i_wr_idx(widx), .o_pw_state(pw), .o_bank_open(bopen), .o_dll_on(dll),
    .o_odt_active(odta), .o_cmd_err(cerr), .o_mr_q(mr), .o_word(word));
  dcp_properties #(.XSRD(XS), .PD_MAX(PDM)) dcp_properties_inst (.i_clk_sys(clk),
    .i_rst_n(rst_n), .cke(bus_if.cke), .cs_n(bus_if.cs_n), .ras_n(bus_if.ras_n),
    .cas_n(bus_if.cas_n), .we_n(bus_if.we_n), .ba(bus_if.ba), .addr(bus_if.addr));
  task automatic conclude();
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wait_pw(input dcp_pw_type s);
    for (int n = 0; n < 100 && pw !== s; n++) @(negedge clk);
    chk("pw_state", s, pw);
  endtask : wait_pw
  // One request held until taken or the wait runs out
  task automatic issue(input dcp_cmd_type c, input logic [1:0] b, input logic [13:0] a,
                       input logic [1:0] m, input logic [15:0] d, input int lim);
    @(negedge clk);
    vld  = 1'b1;
    cmd  = c;
    ba   = b;
    addr = a;
    dm   = m;
    dq   = d;
    for (int n = 0; n < lim && rdy !== 1'b1; n++) @(negedge clk);
    tk = rdy;
    if (tk === 1'b1) @(negedge clk);
    vld = 1'b0;
    repeat (6) @(negedge clk);
  endtask : issue
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    chk("bank_open", 4'h0, bopen);
    issue(DCP_CMD_MRS, MR_EMR1, ODT_EN_MASK, 2'h0, 16'h0000, 50);
    issue(DCP_CMD_MRS, 2'h0, 14'h0123, 2'h0, 16'h0000, 50);
    chk("mr1", ODT_EN_MASK, mr[1]);
    chk("mr0", 14'h0123, mr[0]);
    odt = 1'b1;
    pd  = 1'b1;
    wait_pw(DCP_PW_PPD);
    chk("odt_pd", 1'b1, odta);
    chk("low_power", 1'b1, lp);
    repeat (PDM + 10) @(negedge clk);
    pd = 1'b0;
    wait_pw(DCP_PW_ON);
    ocd = 1'b1;
    pd  = 1'b1;
    repeat (20) @(negedge clk);
    chk("cke_ocd", 1'b1, bus_if.cke);
    pd  = 1'b0;
    ocd = 1'b0;
    issue(DCP_CMD_ACT, 2'h2, 14'h0005, 2'h0, 16'h0000, 50);
    chk("bank_open", 4'h4, bopen);
    issue(DCP_CMD_ACT, 2'h2, 14'h0009, 2'h0, 16'h0000, 20);
    chk("act_taken", 1'b0, tk);
    pd = 1'b1;
    wait_pw(DCP_PW_APD);
    pd = 1'b0;
    wait_pw(DCP_PW_ON);
    chk("low_power", 1'b0, lp);
    chk("bank_open", 4'h4, bopen);
    issue(DCP_CMD_WR, 2'h2, 14'h0000, 2'h0, 16'h1234, 50);
    issue(DCP_CMD_WR, 2'h2, 14'h0000, 2'h2, 16'hABCD, 50);
    chk("word", 16'h12CD, word);
    issue(DCP_CMD_WR, 2'h2, 14'h0000, 2'h1, 16'h5566, 50);
    chk("word", 16'h55CD, word);
    issue(DCP_CMD_WR, 2'h2, 14'h0000, 2'h3, 16'hFFFF, 50);
    chk("word", 16'h55CD, word);
    chk("cmd_err", 1'b0, cerr_seen);
    issue(DCP_CMD_RD, 2'h2, 14'h0000, 2'h0, 16'h0000, 50);
    issue(DCP_CMD_ACT, 2'h0, 14'h0007, 2'h0, 16'h0000, 50);
    chk("bank_open", 4'h5, bopen);
    issue(DCP_CMD_PRE, 2'h2, 14'h0000, 2'h0, 16'h0000, 50);
    chk("bank_open", 4'h1, bopen);
    issue(DCP_CMD_PRE, 2'h0, 14'h0400, 2'h0, 16'h0000, 50);
    chk("bank_open", 4'h0, bopen);
    issue(DCP_CMD_REF, 2'h0, 14'h0000, 2'h0, 16'h0000, 50);
    sr = 1'b1;
    wait_pw(DCP_PW_SR);
    chk("dll_sr", 1'b0, dll);
    chk("odt_sr", 1'b0, odta);
    repeat (10) @(negedge clk);
    sr = 1'b0;
    wait_pw(DCP_PW_ON);
    chk("dll_on", 1'b1, dll);
    issue(DCP_CMD_ACT, 2'h1, 14'h0010, 2'h0, 16'h0000, 50);
    chk("bank_open", 4'h2, bopen);
    chk("cmd_err", 1'b0, cerr_seen);
    conclude();
  end
endmodule : tb_ddr2_cke_power_state_commands
`default_nettype wire
